/* hw/pbs_pkg.sv */
package pbs_pkg;

  // ==========================================================
  // lamp colours, bits {red, green, blue}
  typedef logic [2:0] pbs_color_t;
  localparam pbs_color_t PBS_OFF     = 3'h0;
  localparam pbs_color_t PBS_BLUE    = 3'h1;
  localparam pbs_color_t PBS_GREEN   = 3'h2;
  localparam pbs_color_t PBS_RED     = 3'h4;
  localparam pbs_color_t PBS_MAGENTA = 3'h5;
  localparam pbs_color_t PBS_YELLOW  = 3'h6;
  localparam pbs_color_t PBS_WHITE   = 3'h7;

  typedef struct packed {
    pbs_color_t core_lamp;
    pbs_color_t mode_erase_lamp;
    pbs_color_t run_program_lamp;
    pbs_color_t debug_verify_lamp;
  } pbs_lamps_t;

  // flash engine phase report
  typedef struct packed {
    logic busy;
    logic ok;
    logic err;
  } pbs_flash_stat_t;

  typedef enum logic [2:0] {
    PBS_PH_IDLE = 3'b000,
    PBS_PH_SEL  = 3'b001,
    PBS_PH_BUSY = 3'b010,
    PBS_PH_OK   = 3'b011,
    PBS_PH_ERR  = 3'b100
  } pbs_phase_t;

  // ==========================================================
  // register map
  localparam logic [7:0]  PBS_OFF_CTRL     = 8'h00;
  localparam logic [7:0]  PBS_OFF_STATUS   = 8'h04;
  localparam logic [7:0]  PBS_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0]  PBS_OFF_IRQ_MASK = 8'h0C;
  localparam int          PBS_CTRL_SKIP    = 0;
  localparam int          PBS_CTRL_WBACK   = 1;
  localparam logic [1:0]  PBS_CTRL_RST     = 2'h0;
  localparam int          PBS_EV_HALT      = 0;
  localparam int          PBS_EV_START     = 1;
  localparam int          PBS_EV_ERASE_ERR = 2;
  localparam int          PBS_EV_PROG_ERR  = 3;
  localparam int          PBS_NEV          = 4;
  localparam logic [3:0]  PBS_IRQ_RST      = 4'h0;

  // ==========================================================
  // timing
  localparam int PBS_CLK_MHZ       = 100;
  localparam int PBS_BLINK_HALF_US = 250000;
  localparam int PBS_BLINK_HALF_CYC = PBS_BLINK_HALF_US * PBS_CLK_MHZ;

endpackage : pbs_pkg

/* hw/pbs_leds.sv */
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module pbs_leds
  import pbs_pkg::*;
#(
  parameter int BLINK_HALF_CYC = PBS_BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // ahb-lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  // panel pins
  input  wire logic            break_request_input_n,
  input  wire logic            core_select_switch,
  input  wire logic            function_select_switch_a,
  input  wire logic            function_select_switch_b,
  input  wire logic            restart_button_n,
  // target debug unit
  input  wire logic            target_running,
  input  wire logic            target_powered,
  input  wire logic            target_connected,
  input  wire logic            target_in_debug,
  input  wire logic            link_established,
  output logic                 halt_request,
  // flash engine
  input  wire pbs_flash_stat_t erase_stat,
  input  wire pbs_flash_stat_t program_stat,
  input  wire pbs_flash_stat_t verify_stat,
  output logic                 flash_start,
  output logic                 do_erase,
  output logic                 do_program,
  output logic                 do_verify,
  // indication
  output pbs_lamps_t           lamps,
  output logic                 irq
);

  // ==========================================================
  // functions
  function automatic pbs_color_t lamp_fn(input logic sel,
      input pbs_flash_stat_t st, input pbs_color_t col,
      input logic blink, input logic skip);
    pbs_phase_t ph;
    pbs_color_t c;
    ph = st.err ? PBS_PH_ERR : st.ok ? PBS_PH_OK :
         st.busy ? PBS_PH_BUSY : sel ? PBS_PH_SEL : PBS_PH_IDLE;
    case (ph)
      PBS_PH_ERR:  c = PBS_RED;
      PBS_PH_OK:   c = (skip && !blink) ? PBS_OFF : PBS_GREEN;
      PBS_PH_BUSY: c = blink ? col : PBS_OFF;
      PBS_PH_SEL:  c = col;
      default:     c = PBS_OFF;
    endcase
    return c;
  endfunction : lamp_fn

  // ==========================================================
  // pin synchronisers
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic       brk_d_r;
  logic       rst_d_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= 5'h11;
      pin_s2_r <= 5'h11;
      brk_d_r  <= 1'b1;
      rst_d_r  <= 1'b1;
    end else begin
      pin_s1_r <= {break_request_input_n, function_select_switch_b,
                   function_select_switch_a, core_select_switch,
                   restart_button_n};
      pin_s2_r <= pin_s1_r;
      brk_d_r  <= pin_s2_r[4];
      rst_d_r  <= pin_s2_r[0];
    end
  end

  logic brk_fall;
  logic restart_press;
  assign brk_fall      = brk_d_r & ~pin_s2_r[4];
  assign restart_press = rst_d_r & ~pin_s2_r[0];

  // ==========================================================
  // switch capture
  logic [1:0] boot_cnt_r;
  logic       core_r;
  logic       fn_a_r;
  logic       fn_b_r;
  logic       boot_load;
  assign boot_load = (boot_cnt_r == 2'h2);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_cnt_r <= 2'h0;
      core_r     <= 1'b0;
      fn_a_r     <= 1'b0;
      fn_b_r     <= 1'b0;
    end else begin
      if (boot_cnt_r != 2'h3) begin
        boot_cnt_r <= boot_cnt_r + 2'h1;
      end
      if (boot_load || restart_press) begin
        core_r <= pin_s2_r[1];
        fn_a_r <= pin_s2_r[2];
        fn_b_r <= pin_s2_r[3];
      end
    end
  end

  logic dbg_mode;
  assign dbg_mode   = ~fn_a_r & ~fn_b_r;
  assign do_erase   = fn_a_r;
  assign do_program = fn_a_r;
  assign do_verify  = fn_b_r;

  // ==========================================================
  // break and start requests
  logic press_d_r;
  logic halt_r;
  logic start_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      press_d_r <= 1'b0;
      halt_r    <= 1'b0;
      start_r   <= 1'b0;
    end else begin
      press_d_r <= restart_press;
      halt_r    <= brk_fall & dbg_mode & target_running;
      // family b leaves the break out
      start_r   <= ~dbg_mode & (press_d_r
                   | (brk_fall & ~core_r));
    end
  end
  assign halt_request = halt_r;
  assign flash_start  = start_r;

  // ==========================================================
  // target disconnect tracking
  logic pwr_d_r;
  logic con_d_r;
  logic disc_r;
  logic disc_set;
  logic disc_clr;
  assign disc_set = (pwr_d_r & ~target_powered)
                  | (con_d_r & ~target_connected);
  assign disc_clr = (~pwr_d_r & target_powered)
                  | (restart_press & target_connected);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_d_r <= 1'b0;
      con_d_r <= 1'b0;
      disc_r  <= 1'b1;
    end else begin
      pwr_d_r <= target_powered;
      con_d_r <= target_connected;
      if (disc_set) begin
        disc_r <= 1'b1;
      end else if (disc_clr) begin
        disc_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // blink divider
  logic [31:0] blink_cnt_r;
  logic        blink_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt_r <= 32'h0;
      blink_r     <= 1'b0;
    end else if (blink_cnt_r == 32'(BLINK_HALF_CYC - 1)) begin
      blink_cnt_r <= 32'h0;
      blink_r     <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  // ==========================================================
  // registers
  logic [1:0]         ctrl_r;
  logic [PBS_NEV-1:0] irq_stat_r;
  logic [PBS_NEV-1:0] irq_mask_r;

  // ==========================================================
  // lamps
  pbs_lamps_t lamps_r;
  pbs_lamps_t lamps_nxt;
  always_comb begin
    lamps_nxt.core_lamp = core_r ? PBS_GREEN : PBS_BLUE;
    if (dbg_mode) begin
      lamps_nxt.mode_erase_lamp   = PBS_BLUE;
      lamps_nxt.run_program_lamp  =
        (target_running | disc_r) ? PBS_RED : PBS_OFF;
      lamps_nxt.debug_verify_lamp =
        (target_in_debug | (disc_r & ~link_established))
        ? PBS_GREEN : PBS_OFF;
    end else begin
      // selected phases start out steady
      lamps_nxt.mode_erase_lamp   = lamp_fn(do_erase, erase_stat,
        PBS_WHITE, blink_r, 1'b0);
      lamps_nxt.run_program_lamp  = lamp_fn(
        do_program | ctrl_r[PBS_CTRL_WBACK], program_stat,
        PBS_MAGENTA, blink_r, ctrl_r[PBS_CTRL_SKIP]);
      lamps_nxt.debug_verify_lamp = lamp_fn(do_verify, verify_stat,
        PBS_YELLOW, blink_r, 1'b0);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamps_r <= '0;
    end else begin
      lamps_r <= lamps_nxt;
    end
  end
  assign lamps = lamps_r;

  // ==========================================================
  // ahb-lite slave
  logic       wr_ph_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic       acc;
  logic       mapped;
  assign acc    = hsel & hready & htrans[1];
  assign mapped = (haddr[31:8] == 24'h0);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r   <= 1'b0;
      wr_addr_r <= 8'h0;
      hrdata_r  <= 32'h0;
    end else begin
      wr_ph_r   <= acc & hwrite & mapped;
      wr_addr_r <= haddr[7:0];
      hrdata_r  <= 32'h0;
      if (acc && !hwrite && mapped) begin
        case (haddr[7:0])
          PBS_OFF_CTRL:     hrdata_r <= {30'h0, ctrl_r};
          PBS_OFF_STATUS:   hrdata_r <= {25'h0, blink_r,
                              ~pin_s2_r[4], disc_r, dbg_mode,
                              fn_b_r, fn_a_r, core_r};
          PBS_OFF_IRQ_STAT: hrdata_r <= {28'h0, irq_stat_r};
          PBS_OFF_IRQ_MASK: hrdata_r <= {28'h0, irq_mask_r};
          default:          hrdata_r <= 32'h0;
        endcase
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r     <= PBS_CTRL_RST;
      irq_mask_r <= PBS_IRQ_RST;
    end else if (wr_ph_r) begin
      if (wr_addr_r == PBS_OFF_CTRL) begin
        ctrl_r <= hwdata[1:0];
      end
      if (wr_addr_r == PBS_OFF_IRQ_MASK) begin
        irq_mask_r <= hwdata[PBS_NEV-1:0];
      end
    end
  end

  // ==========================================================
  // interrupts
  logic               eerr_d_r;
  logic               perr_d_r;
  logic [PBS_NEV-1:0] ev;
  logic [PBS_NEV-1:0] w1c;
  always_comb begin
    ev                   = '0;
    ev[PBS_EV_HALT]      = halt_r;
    ev[PBS_EV_START]     = start_r;
    ev[PBS_EV_ERASE_ERR] = erase_stat.err & ~eerr_d_r;
    ev[PBS_EV_PROG_ERR]  = program_stat.err & ~perr_d_r;
    w1c = (wr_ph_r && wr_addr_r == PBS_OFF_IRQ_STAT)
          ? hwdata[PBS_NEV-1:0] : '0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eerr_d_r   <= 1'b0;
      perr_d_r   <= 1'b0;
      irq_stat_r <= PBS_IRQ_RST;
    end else begin
      eerr_d_r   <= erase_stat.err;
      perr_d_r   <= program_stat.err;
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // ==========================================================
  // checks
  chk_halt_on_break: assert property (@(posedge hclk)
    disable iff (!hresetn)
    brk_fall && dbg_mode && target_running |=> halt_request)
    else $error("break did not halt running target");
  chk_break_starts_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    brk_fall && !dbg_mode && !core_r && !restart_press
    |=> flash_start)
    else $error("break did not start flash sequence");
  chk_break_ignored_b: assert property (@(posedge hclk)
    disable iff (!hresetn)
    !dbg_mode && core_r && !press_d_r |=> !flash_start)
    else $error("break acted for family b");
  chk_core_lamp_col: assert property (@(posedge hclk)
    disable iff (!hresetn)
    hresetn |=> lamps.core_lamp == ($past(core_r) ? PBS_GREEN : PBS_BLUE))
    else $error("core lamp colour wrong");
  chk_mode_lamp_blue: assert property (@(posedge hclk)
    disable iff (!hresetn)
    hresetn && dbg_mode && $stable(dbg_mode)
    |=> lamps.mode_erase_lamp == PBS_BLUE)
    else $error("mode lamp not blue in debug mode");
  chk_run_lamp_red: assert property (@(posedge hclk)
    disable iff (!hresetn)
    hresetn && dbg_mode && (target_running || disc_r)
    |=> lamps.run_program_lamp == PBS_RED)
    else $error("run lamp not red");
  chk_disc_clear: assert property (@(posedge hclk)
    disable iff (!hresetn)
    $rose(target_powered) && !disc_set |=> !disc_r)
    else $error("disconnect not cleared on power-on");
  chk_dbg_lamp_green: assert property (@(posedge hclk)
    disable iff (!hresetn)
    hresetn && dbg_mode && target_in_debug
    |=> lamps.debug_verify_lamp == PBS_GREEN)
    else $error("debug lamp not green");
  chk_erase_err_red: assert property (@(posedge hclk)
    disable iff (!hresetn)
    !dbg_mode && erase_stat.err |=> lamps.mode_erase_lamp == PBS_RED)
    else $error("erase error not red");
  chk_switch_hold: assert property (@(posedge hclk)
    disable iff (!hresetn)
    boot_cnt_r == 2'h3 && !restart_press
    |=> $stable(core_r) && $stable(fn_a_r) && $stable(fn_b_r))
    else $error("switches resampled without restart");
  chk_press_start: assert property (@(posedge hclk)
    disable iff (!hresetn)
    restart_press && pin_s2_r[3:2] != 2'h0 |=> ##1 flash_start)
    else $error("restart did not start flash sequence");
  chk_irq_level: assert property (@(posedge hclk)
    disable iff (!hresetn)
    hresetn |=> irq == |($past(irq_stat_r & ~w1c | ev) & irq_mask_r))
    else $error("irq level does not follow status and mask");

endmodule : pbs_leds

/* hw/pbs_dummy_removed.sv */
`timescale 1ns/10ps

/* testbench/pbs_target_model.sv */
`timescale 1ns/10ps
module pbs_target_model
  import pbs_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // bench controls
  input  wire logic       run_cmd,
  input  wire logic       erase_fail,
  // device requests
  input  wire logic       halt_request,
  input  wire logic       flash_start,
  input  wire logic       do_erase,
  input  wire logic       do_program,
  // target and flash status
  output logic            target_running,
  output logic            target_in_debug,
  output pbs_flash_stat_t erase_stat,
  output pbs_flash_stat_t program_stat
);
  logic [1:0] halt_cnt_r;
  logic [5:0] fl_cnt_r;
  logic       e_done;
  logic       p_done;
  // ==========================================================
  // core stops a few instructions after a halt request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_running <= 1'b0;
      halt_cnt_r     <= 2'h0;
    end else if (run_cmd) begin
      target_running <= 1'b1;
    end else if (halt_request && target_running) begin
      halt_cnt_r <= 2'h3;
    end else if (halt_cnt_r != 2'h0) begin
      halt_cnt_r     <= halt_cnt_r - 2'h1;
      target_running <= (halt_cnt_r != 2'h1);
    end
  end
  assign target_in_debug = !target_running;
  // ==========================================================
  // flash engine: erase phase then program phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      fl_cnt_r <= 6'h00;
    else if (flash_start)
      fl_cnt_r <= 6'h01;
    else if (fl_cnt_r != 6'h00 && fl_cnt_r != 6'h31)
      fl_cnt_r <= fl_cnt_r + 6'h01;
  end
  assign e_done       = fl_cnt_r > 6'h18;
  assign p_done       = fl_cnt_r == 6'h31;
  assign erase_stat   = {do_erase & (fl_cnt_r != 6'h00) & !e_done,
                         do_erase & e_done & !erase_fail,
                         do_erase & e_done & erase_fail};
  assign program_stat = {do_program & e_done & !p_done & !erase_fail,
                         do_program & p_done & !erase_fail, 1'b0};
endmodule : pbs_target_model

/* testbench/pbs_leds_test.sv */
`timescale 1ns/10ps
module pbs_leds_test
  import pbs_pkg::*;
;
  logic            hclk, hresetn, hsel, hwrite;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic [31:0]     haddr, hwdata, hrdata, rd;
  logic            hreadyout, hresp, irq, halt_request, flash_start;
  logic            brk_n, core_sw, fn_a, fn_b, rst_n, run_cmd;
  logic            powered, connected, link, erase_fail;
  logic            running, in_dbg, do_erase, do_program, do_verify;
  pbs_flash_stat_t erase_stat, program_stat;
  pbs_lamps_t      lamps;
  int              miscompares, n_tests, n_halt, n_start;

  pbs_leds #(.BLINK_HALF_CYC(4)) pbs_leds_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .break_request_input_n(brk_n),
    .core_select_switch(core_sw), .function_select_switch_a(fn_a),
    .function_select_switch_b(fn_b), .restart_button_n(rst_n),
    .target_running(running), .target_powered(powered),
    .target_connected(connected), .target_in_debug(in_dbg),
    .link_established(link), .halt_request(halt_request),
    .erase_stat(erase_stat), .program_stat(program_stat),
    .verify_stat(3'h0), .flash_start(flash_start),
    .do_erase(do_erase), .do_program(do_program),
    .do_verify(do_verify),
    .lamps(lamps), .irq(irq));

  pbs_target_model pbs_target_model_i (
    .hclk(hclk), .hresetn(hresetn), .run_cmd(run_cmd),
    .erase_fail(erase_fail), .halt_request(halt_request),
    .flash_start(flash_start), .do_erase(do_erase),
    .do_program(do_program), .target_running(running),
    .target_in_debug(in_dbg), .erase_stat(erase_stat),
    .program_stat(program_stat));

  // ==========================================================
  // clock, pulse counters, watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (halt_request === 1'b1) n_halt++;
    if (flash_start === 1'b1) n_start++;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    final_report;
  end

  // ==========================================================
  // helpers
  task chk_word(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_word
  task chk_flag(input logic f, input string m);
    n_tests++;
    if (f !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk_flag
  task chk_lamp(input int i, input pbs_color_t c, input int n,
                input string m);
    logic ok;
    ok = 1'b0;
    for (int k = 0; k < n && !ok; k++) begin
      @(posedge hclk);
      ok = lamps[3*(3-i)+:3] === c;
    end
    chk_flag(ok, m);
  endtask : chk_lamp
  task blink(input int i, input pbs_color_t c, input string m);
    logic on, off;
    on  = 1'b0;
    off = 1'b0;
    repeat (12) begin
      @(posedge hclk);
      on  = on | (lamps[3*(3-i)+:3] === c);
      off = off | (lamps[3*(3-i)+:3] === PBS_OFF);
    end
    chk_flag(on & off, m);
  endtask : blink
  task bus(input logic w, input logic [31:0] a, d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task do_reset;
    hresetn <= 1'b0;
    n_halt  = 0;
    n_start = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : do_reset
  task pin_pulse(input logic restart);
    if (restart) rst_n <= 1'b0;
    else brk_n <= 1'b0;
    repeat (8) @(posedge hclk);
    rst_n <= 1'b1;
    brk_n <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask : pin_pulse

  // ==========================================================
  // scenarios
  task t_debug;
    do_reset;
    chk_lamp(0, PBS_BLUE, 2, "core a");
    chk_lamp(1, PBS_BLUE, 2, "debug mode");
    chk_lamp(2, PBS_RED, 2, "unpowered");
    chk_lamp(3, PBS_GREEN, 2, "no link");
    bus(1'b0, {24'h0, PBS_OFF_STATUS}, 32'h0);
    chk_word(rd & 32'h3F, 32'h18, "status");
    chk_flag(hreadyout === 1'b1 && hresp === 1'b0, "okay");
    bus(1'b0, 32'h100, 32'h0);
    chk_word(rd, 32'h0, "unmapped");
    powered   <= 1'b1;
    connected <= 1'b1;
    link      <= 1'b1;
    chk_lamp(2, PBS_OFF, 4, "powered");
    run_cmd <= 1'b1;
    @(posedge hclk);
    run_cmd <= 1'b0;
    chk_lamp(2, PBS_RED, 4, "running");
    chk_lamp(3, PBS_OFF, 4, "running dbg");
    pin_pulse(1'b0);
    chk_word(n_halt, 32'h1, "halt");
    chk_lamp(3, PBS_GREEN, 8, "halted");
    bus(1'b0, {24'h0, PBS_OFF_IRQ_STAT}, 32'h0);
    chk_word(rd, 32'h1, "halt event");
    chk_flag(irq === 1'b0, "irq masked");
    bus(1'b1, {24'h0, PBS_OFF_IRQ_MASK}, 32'h1);
    @(posedge hclk);
    chk_flag(irq === 1'b1, "irq on");
    bus(1'b1, {24'h0, PBS_OFF_IRQ_STAT}, 32'h1);
    @(posedge hclk);
    chk_flag(irq === 1'b0, "irq cleared");
    connected <= 1'b0;
    chk_lamp(2, PBS_RED, 4, "unplugged");
    connected <= 1'b1;
    pin_pulse(1'b1);
    chk_lamp(2, PBS_OFF, 4, "replugged");
    chk_word(n_start, 32'h0, "no start");
    $display("t_debug done");
  endtask : t_debug

  task t_flash_b;
    core_sw <= 1'b1;
    fn_a    <= 1'b1;
    fn_b    <= 1'b1;
    do_reset;
    chk_lamp(0, PBS_GREEN, 2, "core b");
    chk_lamp(1, PBS_WHITE, 2, "erase sel");
    chk_lamp(2, PBS_MAGENTA, 2, "prog sel");
    chk_lamp(3, PBS_YELLOW, 2, "verify sel");
    bus(1'b1, {24'h0, PBS_OFF_CTRL}, 32'h1);
    pin_pulse(1'b0);
    chk_word(n_start, 32'h0, "break b");
    pin_pulse(1'b1);
    chk_word(n_start, 32'h1, "restart");
    blink(1, PBS_WHITE, "erasing");
    chk_lamp(1, PBS_GREEN, 30, "erase ok");
    blink(2, PBS_MAGENTA, "programming");
    chk_lamp(2, PBS_GREEN, 40, "prog ok");
    blink(2, PBS_GREEN, "skip ok");
    bus(1'b0, {24'h0, PBS_OFF_IRQ_STAT}, 32'h0);
    chk_word(rd, 32'h2, "start event");
    $display("t_flash_b done");
  endtask : t_flash_b

  task t_flash_a;
    core_sw    <= 1'b0;
    fn_b       <= 1'b0;
    erase_fail <= 1'b1;
    do_reset;
    chk_lamp(3, PBS_OFF, 2, "verify off");
    fn_b <= 1'b1;
    repeat (4) @(posedge hclk);
    chk_lamp(3, PBS_OFF, 4, "no relatch");
    fn_b <= 1'b0;
    pin_pulse(1'b0);
    chk_word(n_start, 32'h1, "break a");
    chk_lamp(1, PBS_RED, 40, "erase err");
    chk_lamp(2, PBS_MAGENTA, 2, "prog idle");
    bus(1'b0, {24'h0, PBS_OFF_IRQ_STAT}, 32'h0);
    chk_word(rd, 32'h6, "err event");
    bus(1'b1, {24'h0, PBS_OFF_IRQ_MASK}, 32'h4);
    @(posedge hclk);
    chk_flag(irq === 1'b1, "irq err");
    fn_a <= 1'b0;
    fn_b <= 1'b1;
    pin_pulse(1'b1);
    chk_flag(do_verify === 1'b1 && do_erase === 1'b0, "verify only");
    chk_lamp(2, PBS_OFF, 4, "prog unsel");
    bus(1'b1, {24'h0, PBS_OFF_CTRL}, 32'h2);
    chk_lamp(2, PBS_MAGENTA, 4, "write-back sel");
    $display("t_flash_a done");
  endtask : t_flash_a

  task final_report;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {brk_n, rst_n, core_sw, fn_a, fn_b} = 5'h18;
    {powered, connected, link, run_cmd, erase_fail} = 5'h0;
    miscompares = 0;
    n_tests     = 0;
    t_debug;
    t_flash_b;
    t_flash_a;
    final_report;
  end
endmodule : pbs_leds_test
